/* File: bench/nfc_arr_model.sv */
`timescale 1ns/1ps
`include "nfc_map.svh"
module nfc_arr_model (
    // read port
    input wire logic [`AW-1:0] addr,
    output logic [15:0] rdata
);
    // pattern keeps the words of any 64K span distinct so a wrong low address shows up
    assign rdata = addr[15:0] ^ 16'hC35A;
endmodule

/* File: bench/tb_nor_flash_bus_and_command_decode.sv */
`timescale 1ns/1ps
`include "nfc_map.svh"
module tb_nor_flash_bus_and_command_decode;
    import nfc_pkg::*;
    localparam logic [15:0] MFR = 16'h3C21; // arbitrary value
    localparam logic [15:0] DEV = 16'h1E07; // arbitrary value
    localparam logic [22:0] B1 = 23'h080000;
    logic CLK = 0, RST_N = 0, E_N = 1, G_N = 1, W_N = 1, L_N = 0;
    logic RESET_PIN_N = 1, DQ_OE, RW_OUT, RW_OE, STANDBY, ARR_ABORT;
    logic [22:0] A = 0, ARR_ADDR, la;
    logic [15:0] DQ_IN = 0, DQ_OUT, ARR_WDATA, ARR_RDATA, qry[3], d;
    logic [2:0] ARR_OP;
    logic [15:0] rq[$];
    logic [47:0] oq[$];
    logic [47:0] nt;
    int failures = 0, comparisons = 0, cycles = 0, oe_cnt = 0;
    nfc_top #(.ERASE_CYC(200), .BLANK_CYC(100), .MFR_CODE(MFR),
        .DEV_CODE(DEV)) u_nfc_top (.CLK(CLK), .RST_N(RST_N), .E_N(E_N),
        .G_N(G_N), .W_N(W_N), .L_N(L_N), .RESET_PIN_N(RESET_PIN_N),
        .A(A), .DQ_IN(DQ_IN), .DQ_OUT(DQ_OUT), .DQ_OE(DQ_OE),
        .RW_OUT(RW_OUT), .RW_OE(RW_OE), .STANDBY(STANDBY),
        .ARR_OP(ARR_OP), .ARR_ADDR(ARR_ADDR), .ARR_WDATA(ARR_WDATA),
        .ARR_RDATA(ARR_RDATA), .ARR_ABORT(ARR_ABORT));
    nfc_arr_model u_nfc_arr_model (.addr(ARR_ADDR), .rdata(ARR_RDATA));
    always #5 CLK = ~CLK;
    function automatic logic [15:0] arr(input logic [22:0] a);
        return a[15:0] ^ 16'hC35A;
    endfunction
    task automatic check(input logic [47:0] seen, input logic [47:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge CLK);
    endtask
    // strobes held 4 cycles so the two-flop sync sees them
    task automatic wr(input logic [22:0] a, input logic [15:0] v);
        tick(1);
        A <= a;
        DQ_IN <= v;
        E_N <= 0;
        W_N <= 0;
        tick(4);
        E_N <= 1;
        W_N <= 1;
        tick(4);
    endtask
    task automatic rd(input logic [22:0] a, input logic [15:0] v);
        tick(1);
        A <= a;
        E_N <= 0;
        G_N <= 0;
        rq.push_back(v);
        tick(6);
        E_N <= 1;
        G_N <= 1;
        tick(4);
        check(DQ_OE, 0);
    endtask
    task automatic wait_ops(input int n);
        repeat (n) if (oq.size() != 0) tick(1);
        check(oq.size(), 0);
    endtask
    // bit 47 of a note marks ops whose write data is meaningless
    always @(posedge CLK) begin
        oe_cnt <= DQ_OE ? oe_cnt + 1 : 0;
        if (DQ_OE === 1'b1 && oe_cnt == 1)
            check(DQ_OUT, rq.pop_front());
        // outputs are unknown until the first reset edge
        if (RST_N && ARR_OP !== 3'h0) begin
            if (oq.size() == 0) begin
                check(ARR_OP, 0);
            end else begin
                nt = oq.pop_front();
                if (nt[47])
                    check({ARR_OP, ARR_ADDR}, nt[41:16]);
                else
                    check({ARR_OP, ARR_ADDR, ARR_WDATA}, nt);
            end
        end
    end
    always @(posedge CLK) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            print_verdict();
        end
    end
    initial begin
        qry = '{16'h0051, 16'h0052, 16'h0059};
        d = 16'($urandom(32'h6567));
        tick(20);
        RST_N <= 1;
        tick(4);
        check(RW_OE, 0);
        check(STANDBY, 1);
        rd(23'h000123, arr(23'h000123));
        wr(0, 16'h0070);
        rd(0, 16'h0080);
        wr(0, 16'h0090);
        rd(0, MFR);
        rd(1, DEV);
        rd(3, `CR_DEFAULT);
        wr(0, 16'h0098);
        foreach (qry[i]) rd(23'h10 + 23'(i), qry[i]);
        wr(0, 16'h00FF);
        rd(23'h000456, arr(23'h000456));
        wr(B1, 16'h0070);
        rd(B1, 16'h0080);
        rd(23'h000456, arr(23'h000456));
        wr(B1, 16'h0060);
        wr(B1, 16'h00D0);
        // program through a latched address, live pins point elsewhere
        d = 16'($urandom);
        la = B1 + 23'h22;
        tick(1);
        A <= la;
        E_N <= 0;
        L_N <= 0;
        tick(4);
        L_N <= 1;
        tick(4);
        E_N <= 1;
        oq.push_back({5'h00, 3'h1, la, d});
        tick(2);
        wr(B1 + 23'h99, 16'h0040);
        wr(B1 + 23'h99, d);
        L_N <= 0;
        wait_ops(1200);
        wr(B1, 16'h0000);
        wr(B1, 16'h0020);
        wr(B1, 16'h0055);
        wr(B1, 16'h0070);
        rd(B1, 16'h00B0);
        wr(B1, 16'h0050);
        rd(B1, 16'h0080);
        oq.push_back({6'h20, 3'h2, B1, 16'h0000});
        wr(B1, 16'h0020);
        wr(B1, 16'h00D0);
        wr(B1, 16'h00B0);
        rd(B1, 16'h0040);
        wr(B1, 16'h00D0);
        tick(20);
        check(STANDBY, 0);
        wait_ops(400);
        tick(4);
        check(STANDBY, 1);
        // buffer program: count 1 means two data words
        oq.push_back({6'h00, 3'h3, B1 + 23'h5, d});
        oq.push_back({6'h00, 3'h3, B1 + 23'h6, ~d});
        oq.push_back({6'h20, 3'h4, B1, 16'h0000});
        wr(B1, 16'h00E8);
        wr(B1, 16'h0001);
        wr(B1 + 23'h5, d);
        wr(B1 + 23'h6, ~d);
        wr(B1, 16'h00D0);
        wait_ops(1200);
        wr(B1, 16'h0020);
        wr(B1, 16'h00D0);
        tick(20);
        RESET_PIN_N <= 0;
        tick(4);
        check(ARR_ABORT, 1);
        RESET_PIN_N <= 1;
        tick(300);
        wr(B1, 16'h0060);
        wr(23'h000400, 16'h0003);
        wr(0, 16'h0090);
        rd(3, 16'h0400);
        tick(1);
        RESET_PIN_N <= 0;
        E_N <= 0;
        G_N <= 0;
        tick(5);
        check(DQ_OE, 0);
        check({RW_OE, RW_OUT}, 2'b10);
        RESET_PIN_N <= 1;
        E_N <= 1;
        G_N <= 1;
        tick(4);
        wr(0, 16'h0090);
        rd(3, `CR_DEFAULT);
        tick(10);
        print_verdict();
    end
endmodule

/* File: logic/nfc_map.svh */
`ifndef NFC_MAP_SVH
`define NFC_MAP_SVH
`define AW 23
`define BANK_LSB 19
`define C_LOCK 8'h01
`define C_SETCR 8'h03
`define C_PROG2 8'h10
`define C_ERASE 8'h20
`define C_LKDN 8'h2F
`define C_PROG 8'h40
`define C_CLRSR 8'h50
`define C_LKSET 8'h60
`define C_RDSR 8'h70
`define C_EFP 8'h80
`define C_RDSIG 8'h90
`define C_RDQRY 8'h98
`define C_SUSP 8'hB0
`define C_BLANK 8'hBC
`define C_PROT 8'hC0
`define C_BLKOK 8'hCB
`define C_CONF 8'hD0
`define C_BUF 8'hE8
`define C_RDARR 8'hFF
`define SR_READY 7
`define SR_ESUS 6
`define SR_ERASE 5
`define SR_PROG 4
`define SR_PSUS 2
`define SR_PROT 1
`define CR_ROLE 4
`define CR_WPOL 10
`define CR_DEFAULT 16'h0010
`define SIG_MFR 2'h0
`define SIG_DEV 2'h1
`define SIG_LOCK 2'h2
`define AOP_NONE 3'h0
`define AOP_WRITE 3'h1
`define AOP_ERASE 3'h2
`define AOP_LOAD 3'h3
`define AOP_COMMIT 3'h4
`define CLK_MHZ 100
`define T_PROG_US 10
`define T_ERASE_US 1000
`define T_BLANK_US 100
`endif

/* File: logic/nfc_pe_if.sv */
`timescale 1ns/1ps
interface nfc_pe_if;
    import nfc_pkg::*;
    logic start;
    nfc_peop_t op;
    logic suspend;
    logic resume;
    logic abort;
    logic clr_err;
    logic seq_err;
    logic prot_err;
    logic busy;
    logic susp;
    logic done;
    nfc_peop_t done_op;
    logic [7:0] sr;
    modport cmd (output start, op, suspend, resume, abort, clr_err,
        seq_err, prot_err, input busy, susp, done, done_op, sr);
    modport pec (input start, op, suspend, resume, abort, clr_err,
        seq_err, prot_err, output busy, susp, done, done_op, sr);
endinterface

/* File: logic/nfc_pec.sv */
`timescale 1ns/1ps
`include "nfc_map.svh"
module nfc_pec
    import nfc_pkg::*;
#(
    parameter int PROG_CYC = 1,
    parameter int ERASE_CYC = 1,
    parameter int BLANK_CYC = 1
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // command side
    nfc_pe_if.pec pe
);
    nfc_peop_t cur;
    logic [31:0] cnt;
    logic [31:0] lim;
    logic [2:0] err;
    logic fin;

    always_comb begin
        unique case (cur)
            PE_ERASE: lim = 32'(ERASE_CYC);
            PE_BLANK: lim = 32'(BLANK_CYC);
            PE_PROG, PE_BUF: lim = 32'(PROG_CYC);
        endcase
    end

    // blank check refuses suspend, so it must still finish on time
    assign fin = pe.busy && !pe.susp
        && !(pe.suspend && cur != PE_BLANK) && cnt == lim - 32'h1;

    // abort leaves the target unfinished; array side is told
    always_ff @(posedge clk) begin
        if (!rst_n || pe.abort) begin // RULE12
            pe.busy <= 1'b0;
            pe.susp <= 1'b0;
            cnt <= 32'h0;
        end else if (pe.start && !pe.busy) begin // RULE16
            pe.busy <= 1'b1;
            cnt <= 32'h0;
        end else if (fin) begin
            pe.busy <= 1'b0;
        end else if (pe.busy) begin
            if (pe.suspend && cur != PE_BLANK) begin
                pe.susp <= 1'b1;
            end else if (pe.resume) begin
                pe.susp <= 1'b0;
            end else if (!pe.susp) begin
                cnt <= cnt + 32'h1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cur <= PE_PROG;
        end else if (pe.start && !pe.busy) begin
            cur <= pe.op;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pe.done <= 1'b0;
        end else begin
            pe.done <= fin && !pe.abort;
        end
    end

    assign pe.done_op = cur;

    // new errors win over a clear in the same cycle
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            err <= 3'h0;
        end else begin
            err <= (pe.clr_err ? 3'h0 : err) // RULE26
                | {pe.seq_err, pe.seq_err, pe.prot_err};
        end
    end

    always_comb begin
        pe.sr = 8'h00;
        pe.sr[`SR_READY] = !pe.busy; // RULE16
        pe.sr[`SR_ESUS] = pe.susp && cur == PE_ERASE;
        pe.sr[`SR_ERASE] = err[2];
        pe.sr[`SR_PROG] = err[1];
        pe.sr[`SR_PSUS] = pe.susp && cur != PE_ERASE;
        pe.sr[`SR_PROT] = err[0];
    end

    property p_abort;
        @(posedge clk) disable iff (!rst_n)
        pe.abort |=> !pe.busy && !pe.done;
    endproperty
    a_abort: assert property (p_abort) // RULE12
        else $error("operation survived abort");

    property p_clr;
        @(posedge clk) disable iff (!rst_n)
        pe.clr_err && !pe.seq_err && !pe.prot_err
            |=> pe.sr[5:4] == 2'h0 && !pe.sr[`SR_PROT];
    endproperty
    a_clr: assert property (p_clr) // RULE26
        else $error("error bits not cleared");

    property p_ready;
        @(posedge clk) disable iff (!rst_n)
        pe.start && !pe.busy && !pe.abort
            |=> !pe.sr[`SR_READY] [*1];
    endproperty
    a_ready: assert property (p_ready) // RULE16
        else $error("ready bit high after start");
endmodule

/* File: logic/nfc_pkg.sv */
package nfc_pkg;
    typedef enum logic [1:0] {
        RM_ARRAY, RM_STATUS, RM_SIG, RM_QUERY
    } nfc_rmode_t;
    typedef enum logic [1:0] {
        PE_PROG, PE_ERASE, PE_BUF, PE_BLANK
    } nfc_peop_t;
endpackage

/* File: logic/nfc_top.sv */
`timescale 1ns/1ps
`include "nfc_map.svh"
// Summary of operation
// [RULE1] host reads with chip and output enable low
// [RULE2] read data follows last read-mode command
// [RULE3] write: chip, write low, output high
// [RULE4] capture on first rising write/chip edge
// [RULE5] latch address on latch-enable rise
// [RULE6] tied-low latch needs address hold after write
// [RULE7] latched address used while latch stays high
// [RULE8] output enable high floats data
// [RULE9] chip high, reset high: standby, float
// [RULE10] standby waits for running operation
// [RULE11] reset pin low: deselected, floating
// [RULE12] reset aborts program or erase
// [RULE13] reset pin low restores configuration
// [RULE14] role bit picks wait or ready pin
// [RULE15] every write goes to command interpreter
// [RULE16] controller times operations, shows status
// [RULE17] reset returns default read configuration
// [RULE18] invalid command sequences are ignored; code flags a wrong second cycle in SR bits 5 and 4 instead
// [RULE19] 70h status, 90h signature, 98h query
// [RULE20] erase 20h/D0h, suspend B0h, resume D0h
// [RULE21] 60h then 01h, 2Fh or D0h
// [RULE22] 60h then 03h loads configuration
// [RULE23] 80h then D0h factory buffer program
// [RULE24] program, clear, buffer, blank, read array
// [RULE25] read array affects addressed bank only
// [RULE26] clear status zeroes errors, keeps mode
module nfc_top
    import nfc_pkg::*;
#(
    parameter int ERASE_CYC = `T_ERASE_US * `CLK_MHZ,
    parameter int BLANK_CYC = `T_BLANK_US * `CLK_MHZ,
    // identity values are arbitrary
    parameter logic [15:0] MFR_CODE = 16'h00A5,
    parameter logic [15:0] DEV_CODE = 16'h005A
) (
    // clock and reset
    input wire logic CLK,
    input wire logic RST_N,
    // host bus pins
    input wire logic E_N,
    input wire logic G_N,
    input wire logic W_N,
    input wire logic L_N,
    input wire logic RESET_PIN_N,
    input wire logic [`AW-1:0] A,
    input wire logic [15:0] DQ_IN,
    output logic [15:0] DQ_OUT,
    output logic DQ_OE,
    output logic RW_OUT,
    output logic RW_OE,
    output logic STANDBY,
    // array side
    output logic [2:0] ARR_OP,
    output logic [`AW-1:0] ARR_ADDR,
    output logic [15:0] ARR_WDATA,
    input wire logic [15:0] ARR_RDATA,
    output logic ARR_ABORT
);
    localparam int PROG_CYC = `T_PROG_US * `CLK_MHZ;

    typedef enum logic [3:0] {
        ST_IDLE, ST_ERASE, ST_PROG, ST_LKSET, ST_BLANK,
        ST_BCNT, ST_BDATA, ST_BCONF, ST_EFP
    } nfc_state_t;

    function automatic logic [3:0] bank_of(input logic [`AW-1:0] a);
        bank_of = a[`AW-1:`BANK_LSB];
    endfunction

    function automatic logic [`AW-1:0] pick(input logic l,
        input logic [`AW-1:0] lat, input logic [`AW-1:0] live);
        pick = l ? lat : live;
    endfunction

    function automatic logic [15:0] qry(input logic [7:0] a);
        unique case (a)
            8'h10: qry = 16'h0051;
            8'h11: qry = 16'h0052;
            8'h12: qry = 16'h0059;
            default: qry = 16'h0000;
        endcase
    endfunction

    nfc_pe_if pe ();

    nfc_pec #(
        .PROG_CYC(PROG_CYC),
        .ERASE_CYC(ERASE_CYC),
        .BLANK_CYC(BLANK_CYC)
    ) u_pec (
        .clk(CLK),
        .rst_n(RST_N),
        .pe(pe.pec)
    );

    logic [4:0] pin1, pin2, pin_p;
    logic [`AW-1:0] a1, a2, a_p, alat, wa, ra, op_addr;
    logic [15:0] d1, d2, d_p, cr, sr_lat;
    logic e_n, g_n, w_n, l_n, rp, l_p, e_p;
    logic wr_on, wr_act, wr_strobe, rd_on, rd_prev, run;
    logic [7:0] cmd;
    logic [3:0] wbank, rbank;
    logic [4:0] bcnt;
    nfc_state_t state, next_state;
    nfc_rmode_t rmode [16];
    logic [15:0] lock, lkdn;
    logic rm_set, arr_load, do_lock, do_unlock, do_lkdn, do_cr;
    nfc_rmode_t rm_val;

    // pins and buses are asynchronous to CLK
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            pin1 <= 5'h1F;
            pin2 <= 5'h1F;
            pin_p <= 5'h1F;
            a1 <= '0;
            a2 <= '0;
            a_p <= '0;
            d1 <= 16'h0000;
            d2 <= 16'h0000;
            d_p <= 16'h0000;
        end else begin
            pin1 <= {E_N, G_N, W_N, L_N, RESET_PIN_N};
            pin2 <= pin1;
            pin_p <= pin2;
            a1 <= A;
            a2 <= a1;
            a_p <= a2;
            d1 <= DQ_IN;
            d2 <= d1;
            d_p <= d2;
        end
    end

    assign {e_n, g_n, w_n, l_n, rp} = pin2;
    assign e_p = pin_p[4];
    assign l_p = pin_p[1];
    assign wr_on = !e_n && !w_n && g_n && rp; // RULE3
    // first rise of either strobe ends the write; data from before it
    assign wr_strobe = wr_act && (e_n || w_n); // RULE4 RULE15
    assign rd_on = !e_n && !g_n && rp; // RULE1
    assign cmd = d_p[7:0];
    assign wa = pick(l_p, alat, a_p); // RULE6 RULE7
    assign ra = pick(l_n, alat, a2); // RULE7
    assign wbank = bank_of(wa);
    assign rbank = bank_of(ra);
    assign run = pe.busy && !pe.susp;

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            wr_act <= 1'b0;
            rd_prev <= 1'b0;
        end else begin
            wr_act <= wr_on;
            rd_prev <= rd_on;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            alat <= '0;
        end else if (!e_p && !l_p && l_n) begin // RULE5
            alat <= a_p;
        end
    end

    always_comb begin
        next_state = state;
        pe.start = 1'b0;
        pe.op = PE_PROG;
        pe.suspend = 1'b0;
        pe.resume = 1'b0;
        pe.abort = !rp; // RULE12
        pe.clr_err = 1'b0;
        pe.seq_err = 1'b0;
        pe.prot_err = 1'b0;
        rm_set = 1'b0;
        rm_val = RM_STATUS;
        arr_load = 1'b0;
        do_lock = 1'b0;
        do_unlock = 1'b0;
        do_lkdn = 1'b0;
        do_cr = 1'b0;
        if (wr_strobe && rp) begin
            unique case (state)
                ST_IDLE: begin
                    case (cmd) // RULE24
                        `C_RDARR: begin
                            rm_set = 1'b1; // RULE25
                            rm_val = RM_ARRAY;
                        end
                        `C_RDSR: rm_set = 1'b1; // RULE19
                        `C_RDSIG: begin
                            rm_set = 1'b1;
                            rm_val = RM_SIG;
                        end
                        `C_RDQRY: begin
                            rm_set = 1'b1;
                            rm_val = RM_QUERY;
                        end
                        `C_CLRSR: pe.clr_err = 1'b1; // RULE26
                        `C_SUSP: pe.suspend = run; // RULE20
                        `C_CONF: pe.resume = pe.susp;
                        `C_ERASE: if (!pe.busy) next_state = ST_ERASE;
                        `C_PROG, `C_PROG2, `C_PROT: begin
                            if (!pe.busy) next_state = ST_PROG;
                        end
                        `C_LKSET: if (!pe.busy) next_state = ST_LKSET;
                        `C_BLANK: if (!pe.busy) next_state = ST_BLANK;
                        `C_BUF: if (!pe.busy) next_state = ST_BCNT;
                        `C_EFP: if (!pe.busy) next_state = ST_EFP;
                        // unknown codes are ignored
                        default: next_state = ST_IDLE; // RULE18
                    endcase
                end
                ST_ERASE, ST_BLANK, ST_BCONF, ST_EFP: begin
                    next_state = ST_IDLE;
                    rm_set = 1'b1;
                    if (state == ST_BLANK ? cmd != `C_BLKOK
                        : cmd != `C_CONF) begin
                        pe.seq_err = 1'b1; // RULE18
                    end else if (lock[wbank] && state != ST_BLANK) begin
                        pe.prot_err = 1'b1;
                    end else begin
                        pe.start = 1'b1; // RULE20 RULE23
                        unique case (state)
                            ST_ERASE: pe.op = PE_ERASE;
                            ST_BLANK: pe.op = PE_BLANK;
                            default: pe.op = PE_BUF;
                        endcase
                    end
                end
                ST_PROG: begin
                    next_state = ST_IDLE;
                    rm_set = 1'b1;
                    pe.prot_err = lock[wbank];
                    pe.start = !lock[wbank];
                end
                ST_LKSET: begin
                    next_state = ST_IDLE;
                    case (cmd) // RULE21
                        `C_LOCK: do_lock = 1'b1;
                        `C_LKDN: do_lkdn = 1'b1;
                        `C_CONF: do_unlock = 1'b1;
                        `C_SETCR: do_cr = 1'b1; // RULE22
                        default: pe.seq_err = 1'b1;
                    endcase
                end
                ST_BCNT: begin
                    next_state = ST_BDATA;
                    rm_set = 1'b1;
                end
                ST_BDATA: begin
                    arr_load = 1'b1;
                    if (bcnt == 5'h00) next_state = ST_BCONF;
                end
            endcase
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_N || !rp) begin
            state <= ST_IDLE;
            bcnt <= 5'h00;
            op_addr <= '0;
        end else begin
            state <= next_state;
            if (wr_strobe && state == ST_BCNT) bcnt <= d_p[4:0];
            if (arr_load) bcnt <= bcnt - 5'h01;
            if (pe.start) op_addr <= wa;
        end
    end

    // per-bank read mode; reset restores array reads in all banks
    generate
        for (genvar b = 0; b < 16; b++) begin : g_bank
            always_ff @(posedge CLK) begin
                if (!RST_N || !rp) begin
                    rmode[b] <= RM_ARRAY; // RULE17
                end else if (rm_set && wbank == 4'(b)) begin
                    rmode[b] <= rm_val; // RULE2 RULE25
                end
            end
        end
    endgenerate

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            lock <= 16'hFFFF;
            lkdn <= 16'h0000;
        end else begin
            if (do_lock || do_lkdn) lock[wbank] <= 1'b1;
            if (do_lkdn) lkdn[wbank] <= 1'b1;
            if (do_unlock && !lkdn[wbank]) lock[wbank] <= 1'b0;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_N || !rp) begin
            cr <= `CR_DEFAULT; // RULE13 RULE17
        end else if (do_cr) begin
            cr <= wa[15:0]; // RULE22
        end
    end

    // status is frozen at the start of each read access
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            sr_lat <= 16'h0000;
        end else if (rd_on && !rd_prev) begin
            sr_lat <= {8'h00, pe.sr}; // RULE16
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            DQ_OUT <= 16'h0000;
            DQ_OE <= 1'b0;
        end else begin
            DQ_OE <= rd_on; // RULE8 RULE9 RULE11
            unique case (rmode[rbank]) // RULE2
                RM_ARRAY: DQ_OUT <= ARR_RDATA;
                RM_STATUS: DQ_OUT <= sr_lat;
                RM_QUERY: DQ_OUT <= qry(ra[7:0]);
                RM_SIG: begin
                    unique case (ra[1:0])
                        `SIG_MFR: DQ_OUT <= MFR_CODE;
                        `SIG_DEV: DQ_OUT <= DEV_CODE;
                        `SIG_LOCK: DQ_OUT <= {14'h0000,
                            lkdn[rbank], lock[rbank]};
                        default: DQ_OUT <= cr;
                    endcase
                end
            endcase
        end
    end

    // wait asserted only while reading a bank that is busy
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            RW_OUT <= 1'b0;
            RW_OE <= 1'b1;
        end else if (cr[`CR_ROLE]) begin
            RW_OUT <= 1'b0; // RULE14
            RW_OE <= !rp;
        end else begin
            RW_OE <= rd_on;
            RW_OUT <= !((rmode[rbank] == RM_ARRAY && run
                && rbank == bank_of(op_addr)) ^ cr[`CR_WPOL]);
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            STANDBY <= 1'b0;
        end else begin
            STANDBY <= e_n && rp && !pe.busy; // RULE9 RULE10
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            ARR_OP <= `AOP_NONE;
            ARR_ADDR <= '0;
            ARR_WDATA <= 16'h0000;
            ARR_ABORT <= 1'b0;
        end else begin
            ARR_ABORT <= !rp && pe.busy; // RULE12
            ARR_OP <= `AOP_NONE;
            ARR_ADDR <= ra;
            if (arr_load) begin
                ARR_OP <= `AOP_LOAD;
                ARR_ADDR <= wa;
                ARR_WDATA <= d_p;
            end else if (pe.start) begin
                ARR_WDATA <= d_p;
            end else if (pe.done && pe.done_op != PE_BLANK) begin
                ARR_ADDR <= op_addr;
                unique case (pe.done_op)
                    PE_PROG: ARR_OP <= `AOP_WRITE;
                    PE_ERASE: ARR_OP <= `AOP_ERASE;
                    default: ARR_OP <= `AOP_COMMIT;
                endcase
            end
        end
    end

    property p_float_g;
        @(posedge CLK) disable iff (!RST_N)
        g_n |=> !DQ_OE;
    endproperty
    a_float_g: assert property (p_float_g) // RULE8
        else $error("data driven with output enable high");

    property p_rst_float;
        @(posedge CLK) disable iff (!RST_N)
        !rp |=> !DQ_OE && !STANDBY;
    endproperty
    a_rst_float: assert property (p_rst_float) // RULE11
        else $error("outputs active in reset");

    property p_cr_dflt;
        @(posedge CLK) disable iff (!RST_N)
        !rp |=> cr == `CR_DEFAULT && state == ST_IDLE;
    endproperty
    a_cr_dflt: assert property (p_cr_dflt) // RULE13
        else $error("configuration not restored");

    property p_ready_low;
        @(posedge CLK) disable iff (!RST_N)
        !rp [*2] |=> RW_OE && !RW_OUT;
    endproperty
    a_ready_low: assert property (p_ready_low) // RULE14
        else $error("ready pin not low in reset");

    property p_stby_busy;
        @(posedge CLK) disable iff (!RST_N)
        pe.busy |=> !STANDBY;
    endproperty
    a_stby_busy: assert property (p_stby_busy) // RULE10
        else $error("standby during operation");

    property p_rdsr;
        @(posedge CLK) disable iff (!RST_N)
        wr_strobe && rp && state == ST_IDLE && cmd == `C_RDSR
            |=> rmode[$past(wbank)] == RM_STATUS;
    endproperty
    a_rdsr: assert property (p_rdsr) // RULE19
        else $error("status mode not entered");

    property p_ignore;
        @(posedge CLK) disable iff (!RST_N)
        wr_strobe && state == ST_IDLE && cmd == 8'h00
            |=> state == ST_IDLE && $stable(cr) && !$rose(pe.busy);
    endproperty
    a_ignore: assert property (p_ignore) // RULE18
        else $error("invalid code acted upon");

    property p_cr_load;
        @(posedge CLK) disable iff (!RST_N)
        rp && do_cr ##1 rp
            |-> cr == $past(wa[15:0]);
    endproperty
    a_cr_load: assert property (p_cr_load) // RULE22
        else $error("configuration not loaded from address");
endmodule
